// ===== core/perf_mon_defs.svh
`ifndef PERF_MON_DEFS_SVH
`define PERF_MON_DEFS_SVH

// register indices; byte address is four times the index
`define CTRL_IDX 2'h0
`define CYCLE_IDX 2'h1
`define EVT0_IDX 2'h2
`define EVT1_IDX 2'h3

// control register fields
`define CTRL_EN_BIT 0
`define CTRL_EVRST_BIT 1
`define CTRL_CCRST_BIT 2
`define CTRL_IE_LSB 4
`define CTRL_OVF_LSB 8
`define CTRL_FAST_BIT 11
`define CTRL_SEL0_LSB 12
`define CTRL_SEL1_LSB 20
`define SEL_W 8
`define CTRL_RESET 32'h0000_0000

// coprocessor numbers
`define DEBUG_COPRO 4'hE
`define SYSCTL_COPRO 4'hF
`define DEBUG_REG_LAST 4'h3

// event codes
`define EVT_IC_MISS 8'h00
`define EVT_IC_NODELIVER 8'h01
`define EVT_DATA_STALL 8'h02
`define EVT_ITLB_MISS 8'h03
`define EVT_DTLB_MISS 8'h04
`define EVT_BRANCH 8'h05
`define EVT_MISPREDICT 8'h06
`define EVT_INSTR 8'h07
`define EVT_BUF_STALL_CYC 8'h08
`define EVT_BUF_STALL_RUN 8'h09
`define EVT_DC_ACCESS 8'h0A
`define EVT_DC_MISS 8'h0B
`define EVT_DC_WB 8'h0C
`define EVT_SW_PC 8'h0D
`define EVT_IMPL_TOP 5'h02

`endif

// ===== core/perf_mon_pkg.sv
`default_nettype none
package perf_mon_pkg;
  typedef enum logic [2:0] {
    OP_READ = 3'b000,
    OP_WRITE = 3'b001,
    OP_LOAD = 3'b010,
    OP_STORE = 3'b011,
    OP_DATA = 3'b100,
    OP_DREAD = 3'b101,
    OP_DWRITE = 3'b110
  } cp_op_t;
  typedef logic [31:0] word_t;
endpackage : perf_mon_pkg
`default_nettype wire

// ===== core/event_select.sv
`timescale 1ns/10ps
`default_nettype none
`include "perf_mon_defs.svh"
module event_select (
  // selection
  input wire logic [7:0] sel,
  // event strobes
  input wire logic ic_miss_fetch,
  input wire logic ic_no_deliver,
  input wire logic data_dep_stall,
  input wire logic itlb_miss,
  input wire logic dtlb_miss,
  input wire logic branch_exec,
  input wire logic branch_mispredict,
  input wire logic instr_exec,
  input wire logic buf_full_stall,
  input wire logic buf_stall_start,
  input wire logic [1:0] dc_access_cnt,
  input wire logic dc_miss,
  input wire logic minidc_miss,
  input wire logic [1:0] dc_wb_half_cnt,
  input wire logic pc_write_sw,
  input wire logic pc_mode_change,
  input wire logic [7:0] impl_evt,
  // increment for this cycle
  output logic [1:0] amount
);
  always_comb begin
    amount = 2'h0;
    case (sel)
      `EVT_IC_MISS: amount = {1'b0, ic_miss_fetch};
      `EVT_IC_NODELIVER: amount = {1'b0, ic_no_deliver};
      `EVT_DATA_STALL: amount = {1'b0, data_dep_stall};
      `EVT_ITLB_MISS: amount = {1'b0, itlb_miss};
      `EVT_DTLB_MISS: amount = {1'b0, dtlb_miss};
      `EVT_BRANCH: amount = {1'b0, branch_exec};
      `EVT_MISPREDICT: amount = {1'b0, branch_mispredict};
      `EVT_INSTR: amount = {1'b0, instr_exec};
      `EVT_BUF_STALL_CYC: amount = {1'b0, buf_full_stall};
      `EVT_BUF_STALL_RUN: amount = {1'b0, buf_stall_start};
      `EVT_DC_ACCESS: amount = dc_access_cnt;
      `EVT_DC_MISS: amount = {1'b0, dc_miss} + {1'b0, minidc_miss};
      `EVT_DC_WB: amount = dc_wb_half_cnt;
      `EVT_SW_PC: amount = {1'b0, pc_write_sw & ~pc_mode_change};
      default: begin
        // reserved codes count nothing
        if (sel[7:3] == `EVT_IMPL_TOP) begin
          amount = {1'b0, impl_evt[sel[2:0]]};
        end
      end
    endcase
  end
endmodule : event_select
`default_nettype wire

// ===== core/perf_monitor.sv
// Added by the designer: register access over APB and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "perf_mon_defs.svh"
module perf_monitor #(
  parameter int ADDR_W = 12
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // coprocessor instruction port
  input wire logic cp_valid,
  input wire logic [3:0] cp_num,
  input wire perf_mon_pkg::cp_op_t cp_op,
  input wire logic cp_priv,
  input wire logic [3:0] cp_reg,
  input wire perf_mon_pkg::word_t cp_wdata,
  output logic cp_ack,
  output logic cp_undef,
  output perf_mon_pkg::word_t cp_rdata,
  // event strobes from pipeline and caches
  input wire logic ic_miss_fetch,
  input wire logic ic_no_deliver,
  input wire logic data_dep_stall,
  input wire logic itlb_miss,
  input wire logic dtlb_miss,
  input wire logic branch_exec,
  input wire logic branch_mispredict,
  input wire logic instr_exec,
  input wire logic buf_full_stall,
  input wire logic [1:0] dc_access_cnt,
  input wire logic dc_miss,
  input wire logic minidc_miss,
  input wire logic [1:0] dc_wb_half_cnt,
  input wire logic pc_write_sw,
  input wire logic pc_mode_change,
  input wire logic [7:0] impl_evt,
  // interrupts
  output logic normal_irq,
  output logic fast_interrupt
);
  import perf_mon_pkg::*;

  localparam int NCNT = 3;

  logic enable_reg;
  logic fast_sel_reg;
  logic [NCNT-1:0] ie_reg;
  logic [NCNT-1:0] ovf_reg;
  logic [NCNT-1:0] ovf_next;
  logic [NCNT-1:0] ovf_set;
  logic [NCNT-1:0] cnt_wr;
  logic [`SEL_W-1:0] sel_reg [0:1];
  word_t cnt_reg [0:NCNT-1];
  logic [1:0] inc [0:NCNT-1];
  logic [1:0] cnt_idx [0:NCNT-1];
  logic buf_stall_prev_reg;
  logic buf_stall_start;

  logic pready_reg;
  logic pslverr_reg;
  word_t prdata_reg;
  logic apb_mapped;
  logic apb_fire;
  logic apb_wr;

  logic cp_ack_reg;
  logic cp_undef_reg;
  word_t cp_rdata_reg;
  logic cp_is_debug;
  logic cp_is_sys;
  logic cp_reject;
  logic cp_take;
  logic cp_wr;

  logic wr_en;
  logic [1:0] wr_idx;
  word_t wr_data;
  word_t ctrl_word;
  logic ev_rst;
  logic cc_rst;
  logic [NCNT-1:0] ie_next;
  logic fast_next;
  logic irq_pend;

  // apb: one wait state so read data comes from a flop
  assign apb_mapped = (paddr[ADDR_W-1:4] == '0) && (paddr[1:0] == 2'h0);
  assign apb_fire = psel & penable & pready_reg;
  assign apb_wr = apb_fire & pwrite & apb_mapped;

  // coprocessor access decode
  assign cp_is_debug = (cp_num == `DEBUG_COPRO);
  assign cp_is_sys = (cp_num == `SYSCTL_COPRO);
  always_comb begin
    cp_reject = ~cp_priv;
    case (cp_op)
      OP_DATA, OP_DREAD, OP_DWRITE: cp_reject = 1'b1;
      OP_LOAD, OP_STORE: begin
        if (cp_is_sys) begin
          cp_reject = 1'b1;
        end
      end
      default: begin
      end
    endcase
    // debug coprocessor only has the four monitor registers
    if (cp_is_debug && cp_reg > `DEBUG_REG_LAST) begin
      cp_reject = 1'b1;
    end
  end
  // other coprocessor numbers belong to other units: no answer
  assign cp_take = cp_valid & (cp_is_debug | cp_is_sys);
  assign cp_wr = cp_take & ~cp_reject & cp_is_debug & ((cp_op == OP_WRITE) | (cp_op == OP_LOAD));

  // apb wins a same-cycle write; the coprocessor write is then lost
  always_comb begin
    wr_en = apb_wr | cp_wr;
    wr_idx = cp_reg[1:0];
    wr_data = cp_wdata;
    if (apb_wr) begin
      wr_idx = paddr[3:2];
      wr_data = pwdata;
    end
  end

  assign ev_rst = wr_en && wr_idx == `CTRL_IDX && wr_data[`CTRL_EVRST_BIT];
  assign cc_rst = wr_en && wr_idx == `CTRL_IDX && wr_data[`CTRL_CCRST_BIT];

  // routing follows a same-cycle control write, so a cleared enable
  // drops the line at the very edge that takes the write
  always_comb begin
    ie_next = ie_reg;
    fast_next = fast_sel_reg;
    if (wr_en && wr_idx == `CTRL_IDX) begin
      ie_next = wr_data[`CTRL_IE_LSB +: NCNT];
      fast_next = wr_data[`CTRL_FAST_BIT];
    end
  end

  always_comb begin
    ctrl_word = `CTRL_RESET;
    ctrl_word[`CTRL_EN_BIT] = enable_reg;
    ctrl_word[`CTRL_IE_LSB +: NCNT] = ie_reg;
    ctrl_word[`CTRL_OVF_LSB +: NCNT] = ovf_reg;
    ctrl_word[`CTRL_FAST_BIT] = fast_sel_reg;
    ctrl_word[`CTRL_SEL0_LSB +: `SEL_W] = sel_reg[0];
    ctrl_word[`CTRL_SEL1_LSB +: `SEL_W] = sel_reg[1];
  end

  // reads see the value before any same-cycle update
  function automatic word_t read_word(input logic [1:0] idx);
    word_t w;
    case (idx)
      `CTRL_IDX: w = ctrl_word;
      `CYCLE_IDX: w = cnt_reg[2];
      `EVT0_IDX: w = cnt_reg[0];
      `EVT1_IDX: w = cnt_reg[1];
      default: w = '0;
    endcase
    return w;
  endfunction : read_word

  // ce low freezes the answer too, stretching the access phase
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= '0;
    end else if (ce) begin
      pready_reg <= psel & penable & ~pready_reg;
      pslverr_reg <= psel & penable & ~pready_reg & ~apb_mapped;
      if (psel & penable & ~pready_reg & ~pwrite & apb_mapped) begin
        prdata_reg <= read_word(paddr[3:2]);
      end else if (psel & penable & ~pready_reg) begin
        prdata_reg <= '0;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cp_ack_reg <= 1'b0;
      cp_undef_reg <= 1'b0;
      cp_rdata_reg <= '0;
    end else if (ce) begin
      cp_ack_reg <= cp_take & ~cp_reject;
      cp_undef_reg <= cp_take & cp_reject;
      if (cp_take & ~cp_reject & cp_is_debug) begin
        cp_rdata_reg <= read_word(cp_reg[1:0]);
      end else if (cp_take) begin
        cp_rdata_reg <= '0;
      end
    end
  end

  // control fields
  // reserved select codes are stored as written and count nothing
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      enable_reg <= 1'b0;
      fast_sel_reg <= 1'b0;
      ie_reg <= '0;
      sel_reg[0] <= '0;
      sel_reg[1] <= '0;
    end else if (ce && wr_en && wr_idx == `CTRL_IDX) begin
      enable_reg <= wr_data[`CTRL_EN_BIT];
      fast_sel_reg <= wr_data[`CTRL_FAST_BIT];
      ie_reg <= wr_data[`CTRL_IE_LSB +: NCNT];
      sel_reg[0] <= wr_data[`CTRL_SEL0_LSB +: `SEL_W];
      sel_reg[1] <= wr_data[`CTRL_SEL1_LSB +: `SEL_W];
    end
  end

  // run detector for buffer-full stalls
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      buf_stall_prev_reg <= 1'b0;
    end else if (ce) begin
      buf_stall_prev_reg <= buf_full_stall;
    end
  end
  assign buf_stall_start = buf_full_stall & ~buf_stall_prev_reg;

  assign cnt_idx[0] = `EVT0_IDX;
  assign cnt_idx[1] = `EVT1_IDX;
  assign cnt_idx[2] = `CYCLE_IDX;
  assign inc[2] = 2'h1;

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_sel
      event_select u_sel (
        .sel(sel_reg[g]),
        .ic_miss_fetch(ic_miss_fetch),
        .ic_no_deliver(ic_no_deliver),
        .data_dep_stall(data_dep_stall),
        .itlb_miss(itlb_miss),
        .dtlb_miss(dtlb_miss),
        .branch_exec(branch_exec),
        .branch_mispredict(branch_mispredict),
        .instr_exec(instr_exec),
        .buf_full_stall(buf_full_stall),
        .buf_stall_start(buf_stall_start),
        .dc_access_cnt(dc_access_cnt),
        .dc_miss(dc_miss),
        .minidc_miss(minidc_miss),
        .dc_wb_half_cnt(dc_wb_half_cnt),
        .pc_write_sw(pc_write_sw),
        .pc_mode_change(pc_mode_change),
        .impl_evt(impl_evt),
        .amount(inc[g])
      );
    end
    for (g = 0; g < NCNT; g = g + 1) begin : g_cnt
      logic [32:0] sum;
      logic clr;
      assign sum = {1'b0, cnt_reg[g]} + {31'h0, inc[g]};
      assign clr = (g == 2) ? cc_rst : ev_rst;
      // a software write or clear beats the count; no overflow then
      assign cnt_wr[g] = wr_en && wr_idx == cnt_idx[g];
      // overflow flag and wrap share one edge
      assign ovf_set[g] = enable_reg & ~cnt_wr[g] & ~clr & sum[32];
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          cnt_reg[g] <= '0;
        end else if (ce) begin
          if (cnt_wr[g]) begin
            cnt_reg[g] <= wr_data;
          end else if (clr) begin
            cnt_reg[g] <= '0;
          end else if (enable_reg) begin
            cnt_reg[g] <= sum[31:0];
          end
        end
      end
    end
  endgenerate

  // write-one-to-clear; a new overflow in the same cycle wins
  always_comb begin
    ovf_next = ovf_reg;
    if (wr_en && wr_idx == `CTRL_IDX) begin
      ovf_next = ovf_reg & ~wr_data[`CTRL_OVF_LSB +: NCNT];
    end
    ovf_next = ovf_next | ovf_set;
  end

  // pending uses next flags and next enables: no one-cycle lag
  assign irq_pend = |(ovf_next & ie_next);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ovf_reg <= '0;
      normal_irq <= 1'b0;
      fast_interrupt <= 1'b0;
    end else if (ce) begin
      ovf_reg <= ovf_next;
      normal_irq <= irq_pend & ~fast_next;
      fast_interrupt <= irq_pend & fast_next;
    end
  end

  // outputs come straight from their flops
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign cp_ack = cp_ack_reg;
  assign cp_undef = cp_undef_reg;
  assign cp_rdata = cp_rdata_reg;
endmodule : perf_monitor
`default_nettype wire

// ===== dv/perf_monitor_properties.sv
`timescale 1ns/10ps
`default_nettype none
module perf_monitor_props
  import perf_mon_pkg::*;
#(parameter int ADDR_W = 12) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  // coprocessor port
  input wire logic cp_valid,
  input wire logic [3:0] cp_num,
  input wire perf_mon_pkg::cp_op_t cp_op,
  input wire logic cp_priv,
  input wire logic [3:0] cp_reg,
  input wire logic cp_ack,
  input wire logic cp_undef,
  // interrupts
  input wire logic normal_irq,
  input wire logic fast_interrupt
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst || !ce);
  logic hit, bad, ctrl_wr;
  assign hit = cp_valid && (cp_num == 4'hE || cp_num == 4'hF);
  assign bad = paddr[1:0] != 2'h0 || paddr >= ADDR_W'(16);
  // any control write may drop an interrupt: flag clear, enable or routing change
  assign ctrl_wr = (psel && penable && pready && pwrite && paddr == '0) ||
    (cp_valid && cp_num == 4'hE && cp_priv && cp_reg == 4'h0 && cp_op inside {OP_WRITE, OP_LOAD});
  a_apb_wait: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
    else $error("apb answer not in second access cycle");
  a_slverr_map: assert property (pready |-> pslverr == bad)
    else $error("error response does not match address map");
  a_cp_answer: assert property (hit |=> cp_ack != cp_undef)
    else $error("coprocessor request without exactly one answer");
  a_cp_silent: assert property (!hit |=> !cp_ack && !cp_undef)
    else $error("coprocessor answer without request");
  a_user_undef: assert property (hit && !cp_priv |=> cp_undef)
    else $error("user mode access not refused");
  a_no_dataop: assert property (hit && cp_op inside {OP_DATA, OP_DREAD, OP_DWRITE} |=> cp_undef)
    else $error("data op or double transfer not refused");
  a_sys_ldst: assert property (cp_valid && cp_num == 4'hF && cp_op inside {OP_LOAD, OP_STORE} |=> cp_undef)
    else $error("load or store to system coprocessor not refused");
  a_debug_ok: assert property (cp_valid && cp_num == 4'hE && cp_priv && cp_reg <= 4'h3 && cp_op inside {OP_READ, OP_WRITE, OP_LOAD, OP_STORE} |=> cp_ack)
    else $error("legal debug access refused");
  a_irq_hold: assert property ($fell(normal_irq) || $fell(fast_interrupt) |-> $past(ctrl_wr))
    else $error("interrupt dropped without control write");
  a_irq_single: assert property (!(normal_irq && fast_interrupt))
    else $error("both interrupt outputs high");
  cover property (hit ##1 cp_undef);
  cover property ($rose(normal_irq));
  cover property ($rose(fast_interrupt));
  cover property (pready && pslverr);
endmodule : perf_monitor_props
bind perf_monitor perf_monitor_props #(.ADDR_W(ADDR_W)) chk_u (.*);
`default_nettype wire

// ===== dv/event_source.sv
`timescale 1ns/10ps
`default_nettype none
module event_source (
  // pattern from the bench
  input wire logic [19:0] rnd,
  // strobes into the monitor
  output logic ic_miss_fetch,
  output logic ic_no_deliver,
  output logic data_dep_stall,
  output logic itlb_miss,
  output logic dtlb_miss,
  output logic branch_exec,
  output logic branch_mispredict,
  output logic instr_exec,
  output logic buf_full_stall,
  output logic [1:0] dc_access_cnt,
  output logic dc_miss,
  output logic minidc_miss,
  output logic [1:0] dc_wb_half_cnt,
  output logic pc_write_sw,
  output logic pc_mode_change,
  output logic [7:0] impl_evt
);
  // a data cache miss or mispredict only comes with its own access or branch
  assign {ic_miss_fetch, ic_no_deliver, data_dep_stall, itlb_miss, dtlb_miss, branch_exec} =
    {rnd[0], rnd[0] | rnd[3], rnd[2], rnd[3], rnd[4], rnd[5]};
  assign {branch_mispredict, instr_exec, buf_full_stall, dc_access_cnt, dc_miss, minidc_miss} =
    {rnd[5] & rnd[6], rnd[7], rnd[8], rnd[10:9], rnd[11] & |rnd[10:9], rnd[12] & |rnd[10:9]};
  assign {dc_wb_half_cnt, pc_write_sw, pc_mode_change, impl_evt} =
    {rnd[14:13], rnd[15], rnd[16], rnd[19:17], rnd[19:15]};
endmodule : event_source
`default_nettype wire

// ===== dv/core_perf_monitor_counters_test.sv
`timescale 1ns/10ps
`default_nettype none
module core_perf_monitor_counters_test;
  import perf_mon_pkg::*;
  logic clk, rst, ce, psel, penable, pwrite, pready, pslverr, bprev, irqv;
  logic cp_valid, cp_priv, cp_ack, cp_undef, normal_irq, fast_interrupt;
  logic [11:0] paddr;
  word_t pwdata, prdata, cp_wdata, cp_rdata, ctrl_m, cyc, e0, e1;
  logic [3:0] cp_num, cp_reg;
  cp_op_t cp_op;
  logic ic_miss_fetch, ic_no_deliver, data_dep_stall, itlb_miss, dtlb_miss, branch_exec;
  logic branch_mispredict, instr_exec, buf_full_stall, dc_miss, minidc_miss;
  logic pc_write_sw, pc_mode_change;
  logic [1:0] dc_access_cnt, dc_wb_half_cnt;
  logic [7:0] impl_evt;
  logic [19:0] rnd;
  logic [2:0] fl;
  logic [32:0] s0, s1, s2;
  logic [34:0] cq;
  logic [33:0] qa[$];
  logic wv;
  logic [1:0] wa;
  word_t wd;
  logic [2:0] wc, fs;
  logic [34:0] qc[$];
  int n_mismatch, checks;
  perf_monitor dut_u (.*);
  event_source src_u (.*);
  initial begin
    clk = 0;
    forever #10 clk = ~clk;
  end
  initial begin
    rnd = '0;
    void'($urandom(40));
    forever begin
      @(posedge clk);
      rnd <= 20'($urandom);
    end
  end
  task check(input logic [33:0] seen, input logic [33:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  function automatic logic [1:0] inc(input logic [7:0] c);
    if (c[7:3] == 5'h02) return {1'b0, impl_evt[c[2:0]]};
    case (c)
      8'h00: return {1'b0, ic_miss_fetch};
      8'h01: return {1'b0, ic_no_deliver};
      8'h02: return {1'b0, data_dep_stall};
      8'h03: return {1'b0, itlb_miss};
      8'h04: return {1'b0, dtlb_miss};
      8'h05: return {1'b0, branch_exec};
      8'h06: return {1'b0, branch_mispredict};
      8'h07: return {1'b0, instr_exec};
      8'h08: return {1'b0, buf_full_stall};
      8'h09: return {1'b0, buf_full_stall & ~bprev};
      8'h0A: return dc_access_cnt;
      8'h0B: return {1'b0, dc_miss} + {1'b0, minidc_miss};
      8'h0C: return dc_wb_half_cnt;
      8'h0D: return {1'b0, pc_write_sw & ~pc_mode_change};
      default: return 2'h0;
    endcase
  endfunction : inc
  function automatic logic [7:0] code(input int i);
    return i < 14 ? 8'(i) : 8'(i + 2);
  endfunction : code
  function automatic word_t val(input logic [1:0] i);
    word_t v[4];
    v = '{ctrl_m | {21'h0, fl, 8'h0}, cyc, e0, e1};
    return v[i];
  endfunction : val
  // reference copy of the counters; a software write lands after the count
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      {ctrl_m, cyc, e0, e1, fl, bprev} <= '0;
    end else if (ce) begin
      bprev <= buf_full_stall;
      s0 = {1'b0, e0} + 33'(inc(ctrl_m[19:12]));
      s1 = {1'b0, e1} + 33'(inc(ctrl_m[27:20]));
      s2 = {1'b0, cyc} + 33'h1;
      wv = psel && penable && pready && pwrite && paddr < 12'h10 && paddr[1:0] == 2'h0;
      {wa, wd} = {paddr[3:2], pwdata};
      if (!wv && cp_valid && cp_num == 4'hE && cp_priv && cp_reg < 4'h4 &&
          cp_op inside {OP_WRITE, OP_LOAD}) begin
        {wv, wa, wd} = {1'b1, cp_reg[1:0], cp_wdata};
      end
      // a counter written or cleared this cycle does not overflow; set beats clear
      wc = {3{wv}} & {wa == 2'h1 || (wa == 2'h0 && wd[2]), wa == 2'h3 || (wa == 2'h0 && wd[1]),
        wa == 2'h2 || (wa == 2'h0 && wd[1])};
      fs = {s2[32], s1[32], s0[32]} & ~wc & {3{ctrl_m[0]}};
      fl <= ((wv && wa == 2'h0) ? fl & ~wd[10:8] : fl) | fs;
      if (ctrl_m[0]) begin
        {e0, e1, cyc} <= {s0[31:0], s1[31:0], s2[31:0]};
      end
      if (wv) begin
        case (wa)
          2'h0: begin
            ctrl_m <= wd & 32'h0FFF_F871;
            if (wd[1]) {e0, e1} <= '0;
            if (wd[2]) cyc <= '0;
          end
          2'h1: cyc <= wd;
          2'h2: e0 <= wd;
          default: e1 <= wd;
        endcase
      end
    end
  end
  assign irqv = |(fl & ctrl_m[6:4]);
  always @(negedge clk) begin
    if (!rst) check({32'h0, fast_interrupt, normal_irq}, {32'h0, ctrl_m[11] & irqv, !ctrl_m[11] & irqv});
  end
  always @(posedge clk) begin
    if (!rst && psel && penable && pready === 1'b1) check({1'b0, pslverr, prdata}, qa.pop_front());
    if (!rst && (cp_ack === 1'b1 || cp_undef === 1'b1)) begin
      cq = qc.pop_front();
      check({cp_ack, cp_undef, cq[34] ? cp_rdata : 32'h0}, cq[33:0]);
    end
  end
  task apb(input logic w, input logic [11:0] a, input word_t d);
    logic bad;
    bad = a[1:0] != 2'h0 || a >= 12'h10;
    qa.push_back({1'b0, bad, (w || bad) ? 32'h0 : val(a[3:2])});
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    {psel, penable} <= 2'b00;
    @(posedge clk);
  endtask : apb
  task cp(input logic [3:0] num, input cp_op_t op, input logic pr, input logic [3:0] r);
    logic u;
    u = !pr || op inside {OP_DATA, OP_DREAD, OP_DWRITE} || (num == 4'hF && op inside {OP_LOAD, OP_STORE}) || (num == 4'hE && r > 4'h3);
    qc.push_back({!u, !u, u, (u || num == 4'hF) ? 32'h0 : val(r[1:0])});
    {cp_valid, cp_num, cp_priv, cp_reg} <= {1'b1, num, pr, r};
    cp_op <= op;
    @(posedge clk);
    cp_valid <= 0;
    @(posedge clk);
  endtask : cp
  task test_done;
    if (qa.size() + qc.size() != 0) n_mismatch++;
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : test_done
  initial begin
    {rst, ce, psel, penable, pwrite, cp_valid, cp_priv, paddr, pwdata} = {2'b11, 49'h0};
    {cp_num, cp_reg, n_mismatch, checks} = '0;
    cp_op = OP_READ;
    cp_wdata = 32'h1234_5670;
    repeat (10) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    for (int i = 0; i < 4; i++) apb(0, 12'(4 * i), '0);
    $display("reset values done");
    for (int i = 0; i < 22; i++) begin
      apb(1, 12'h0, 32'h6);
      apb(1, 12'h0, {4'h0, code(21 - i), code(i), 12'h001});
      repeat (6) @(posedge clk);
      ce <= i[0];
      repeat (6) @(posedge clk);
      ce <= 1'b1;
      apb(1, 12'h0, {4'h0, code(21 - i), code(i), 12'h000});
      for (int r = 0; r < 4; r++) apb(0, 12'(4 * r), '0);
    end
    $display("event codes done");
    for (int f = 0; f < 2; f++) begin
      apb(1, 12'h4, 32'hFFFF_FFFC);
      apb(1, 12'h8, 32'hFFFF_FFF8);
      apb(1, 12'hC, 32'hFFFF_FFFF);
      apb(1, 12'h0, {4'h0, 8'h0A, 8'h07, f[0], 4'h0, f ? 3'h5 : 3'h7, 4'h1});
      repeat (16) @(posedge clk);
      apb(1, 12'h0, '0);
      for (int r = 0; r < 4; r++) apb(0, 12'(4 * r), '0);
      apb(1, 12'h0, 32'h700);
      apb(0, 12'h0, '0);
    end
    $display("overflow done");
    apb(0, 12'h10, '0);
    apb(0, 12'h2, '0);
    apb(1, 12'h14, 32'hFFFF_FFFF);
    for (int r = 0; r < 4; r++) apb(0, 12'(4 * r), '0);
    $display("unmapped done");
    for (int k = 0; k < 28; k++) begin
      cp(k[0] ? 4'hF : 4'hE, cp_op_t'(k / 4), k[1], 4'(k % 5));
    end
    for (int r = 0; r < 4; r++) apb(0, 12'(4 * r), '0);
    $display("coprocessor done");
    test_done;
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    test_done;
  end
endmodule : core_perf_monitor_counters_test
`default_nettype wire
